/* File: core/supervisor_map.vh */
// Constants and timing counts for the dual supply reset watchdog
`ifndef SUPERVISOR_MAP_VH
`define SUPERVISOR_MAP_VH

`define CLOCK_HZ          40000000
`define RESET_TIMEOUT_MS  140
`define WATCHDOG_TIMEOUT_MS 1600
`define RESET_TIMEOUT_CYC    ((`CLOCK_HZ / 1000) * `RESET_TIMEOUT_MS)
`define WATCHDOG_TIMEOUT_CYC ((`CLOCK_HZ / 1000) * `WATCHDOG_TIMEOUT_MS)
`define TIMER_WIDTH       32
`define SUPPLY_COUNT      2

`define ST_HOLD    2'h0
`define ST_DELAY   2'h1
`define ST_RUN     2'h2

`endif

/* File: core/input_sync.v */
// Two flip-flop synchroniser for one asynchronous input
`timescale 1ns/1ps
module input_sync #(
    parameter RESET_VALUE = 1'b0
) (
    input  wire clock,
    input  wire reset_n,
    input  wire async_in,
    output reg  sync_out
);
    reg meta_r;

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_r   <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

/* File: core/dual_supply_reset_watchdog.v */
// Dual supply supervisor with reset timeout and watchdog
`timescale 1ns/1ps
`include "supervisor_map.vh"
module dual_supply_reset_watchdog #(
    parameter [`TIMER_WIDTH-1:0] RESET_TIMEOUT_CYCLES    = `RESET_TIMEOUT_CYC,
    parameter [`TIMER_WIDTH-1:0] WATCHDOG_TIMEOUT_CYCLES = `WATCHDOG_TIMEOUT_CYC
) (
    input  wire                     clock,
    input  wire                     reset_n,
    input  wire [`SUPPLY_COUNT-1:0] supply_sense_in,
    input  wire                     manual_reset_request_n,
    input  wire                     watchdog_strobe_in,
    output reg                      reset_out,
    output reg                      reset_out_n
);
    reg                     rst_meta_r;
    reg                     rst_sync_n_r;
    wire [`SUPPLY_COUNT-1:0] sense_s;
    wire                    manual_n_s;
    wire                    strobe_s;
    reg                     strobe_prev_r;
    reg  [1:0]              state_r;
    reg  [1:0]              state_nxt;
    reg  [`TIMER_WIDTH-1:0] delay_cnt_r;
    reg  [`TIMER_WIDTH-1:0] delay_cnt_nxt;
    reg  [`TIMER_WIDTH-1:0] wd_cnt_r;
    reg  [`TIMER_WIDTH-1:0] wd_cnt_nxt;
    wire                    supplies_good;
    wire                    strobe_edge;
    wire                    fault;

    // State codes
    localparam [1:0] ST_HOLD  = `ST_HOLD;
    localparam [1:0] ST_DELAY = `ST_DELAY;
    localparam [1:0] ST_RUN   = `ST_RUN;

    // Reset release through two flops
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r   <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r   <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `SUPPLY_COUNT; i = i + 1) begin : g_sense
            input_sync #(.RESET_VALUE(1'b0)) u_sense (
                .clock    (clock),
                .reset_n  (rst_sync_n_r),
                .async_in (supply_sense_in[i]),
                .sync_out (sense_s[i])
            );
        end
    endgenerate

    // Manual request resets high so reset is not held by the synchroniser
    input_sync #(.RESET_VALUE(1'b1)) u_manual (
        .clock    (clock),
        .reset_n  (rst_sync_n_r),
        .async_in (manual_reset_request_n),
        .sync_out (manual_n_s)
    );

    input_sync #(.RESET_VALUE(1'b0)) u_strobe (
        .clock    (clock),
        .reset_n  (rst_sync_n_r),
        .async_in (watchdog_strobe_in),
        .sync_out (strobe_s)
    );

    assign supplies_good = &sense_s;
    assign strobe_edge   = strobe_s ^ strobe_prev_r;
    assign fault         = !supplies_good || !manual_n_s;

    always @* begin
        state_nxt     = state_r;
        delay_cnt_nxt = delay_cnt_r;
        wd_cnt_nxt    = wd_cnt_r;
        case (state_r)
            ST_HOLD: begin
                delay_cnt_nxt = {`TIMER_WIDTH{1'b0}};
                if (!fault) begin
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (fault) begin
                    state_nxt = ST_HOLD;
                end else if (delay_cnt_r >= RESET_TIMEOUT_CYCLES - 1'b1) begin
                    state_nxt  = ST_RUN;
                    wd_cnt_nxt = {`TIMER_WIDTH{1'b0}};
                end else begin
                    delay_cnt_nxt = delay_cnt_r + 1'b1;
                end
            end
            ST_RUN: begin
                if (fault) begin
                    state_nxt = ST_HOLD;
                end else if (strobe_edge) begin
                    wd_cnt_nxt = {`TIMER_WIDTH{1'b0}};
                end else if (wd_cnt_r >= WATCHDOG_TIMEOUT_CYCLES - 1'b1) begin
                    // Expiry runs the full reset timeout again
                    state_nxt     = ST_DELAY;
                    delay_cnt_nxt = {`TIMER_WIDTH{1'b0}};
                end else begin
                    wd_cnt_nxt = wd_cnt_r + 1'b1;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    // Outputs asserted from the first moment of power-up
    always @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            state_r       <= ST_HOLD;
            delay_cnt_r   <= {`TIMER_WIDTH{1'b0}};
            wd_cnt_r      <= {`TIMER_WIDTH{1'b0}};
            strobe_prev_r <= 1'b0;
            reset_out     <= 1'b1;
            reset_out_n   <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            delay_cnt_r   <= delay_cnt_nxt;
            wd_cnt_r      <= wd_cnt_nxt;
            strobe_prev_r <= strobe_s;
            reset_out     <= (state_nxt != ST_RUN);
            reset_out_n   <= (state_nxt == ST_RUN);
        end
    end
endmodule

/* File: tb/supervisor_sva.sv */
// Checker for the reset outputs of the supervisor
`timescale 1ns/1ps
module supervisor_sva #(parameter int RST = 20, parameter int WDT = 60) (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [1:0] supply_sense_in,
    input wire logic       manual_reset_request_n,
    input wire logic       watchdog_strobe_in,
    input wire logic       reset_out,
    input wire logic       reset_out_n
);
    wire good = &supply_sense_in && manual_reset_request_n;
    int  rel_cnt_r;
    int  wd_cnt_r;
    // Bounds carry slack for the input synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rel_cnt_r <= 0;
            wd_cnt_r  <= 0;
        end else begin
            rel_cnt_r <= (reset_out && good) ? rel_cnt_r + 1 : 0;
            wd_cnt_r  <= (reset_out || $changed(watchdog_strobe_in)) ? 0 : wd_cnt_r + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_COMPL: assert property (reset_out_n == !reset_out) else $error("outputs not complementary");
    AST_PWRUP: assert property ($rose(reset_n) |-> reset_out [*3]) else $error("no reset at start");
    AST_HOLD: assert property (!(&supply_sense_in) [*4] |-> reset_out) else $error("supply low");
    AST_MANUAL: assert property (!manual_reset_request_n [*4] |-> reset_out) else $error("manual");
    AST_REL_MIN: assert property ($fell(reset_out) |-> rel_cnt_r >= RST - 1) else $error("early");
    AST_REL_MAX: assert property (rel_cnt_r <= RST + 6) else $error("late release");
    AST_WD_MAX: assert property (wd_cnt_r <= WDT + 5) else $error("watchdog missed");
    AST_NO_EARLY: assert property ($rose(reset_out) |-> wd_cnt_r >= WDT - 2 || !$past(good)
        || !$past(good, 2) || !$past(good, 3) || !$past(good, 4)) else $error("spurious reset");
endmodule
bind dual_supply_reset_watchdog supervisor_sva #(.RST(RESET_TIMEOUT_CYCLES), .WDT(WATCHDOG_TIMEOUT_CYCLES))
    supervisor_sva_i (.clock(clock), .reset_n(reset_n), .supply_sense_in(supply_sense_in),
    .manual_reset_request_n(manual_reset_request_n), .watchdog_strobe_in(watchdog_strobe_in),
    .reset_out(reset_out), .reset_out_n(reset_out_n));

/* File: tb/cpu_model.sv */
// Processor model strobing the watchdog
`timescale 1ns/1ps
module cpu_model (
    input  wire logic clock,
    input  wire logic reset_out_n,
    input  wire logic strobe_en,
    output var logic  watchdog_strobe_in
);
    int count_r = 0;
    initial watchdog_strobe_in = 1'h0;
    // Toggle every 8 cycles, well above the minimum pulse width
    always @(posedge clock) begin
        count_r <= (count_r == 7) ? 0 : count_r + 1;
        if (count_r == 7 && strobe_en && reset_out_n) watchdog_strobe_in <= #2 !watchdog_strobe_in;
    end
endmodule

/* File: tb/dual_supply_reset_watchdog_bench.sv */
// Bench for the dual supply reset watchdog
`timescale 1ns/1ps
module dual_supply_reset_watchdog_bench;
    localparam int RST = 32'h0000_0014;
    localparam int WDT = 32'h0000_003C;
    logic       clock = 1'h0;
    logic       reset_n = 1'h0;
    logic [1:0] supply_sense_in = 2'h0;
    logic       manual_reset_request_n = 1'h1;
    logic       strobe_en = 1'h1;
    wire        watchdog_strobe_in;
    wire        reset_out;
    wire        reset_out_n;
    int         miscompares = 0;
    int         num_checks = 0;
    int         ticks = 0;
    dual_supply_reset_watchdog #(.RESET_TIMEOUT_CYCLES(RST), .WATCHDOG_TIMEOUT_CYCLES(WDT))
        dual_supply_reset_watchdog_i (.clock(clock), .reset_n(reset_n), .supply_sense_in(supply_sense_in),
        .manual_reset_request_n(manual_reset_request_n), .watchdog_strobe_in(watchdog_strobe_in),
        .reset_out(reset_out), .reset_out_n(reset_out_n));
    cpu_model cpu_model_i (.clock(clock), .reset_out_n(reset_out_n), .strobe_en(strobe_en),
        .watchdog_strobe_in(watchdog_strobe_in));
    initial forever #12.5 clock = ~clock;
    task test_done;
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clock) if (++ticks > 3000) begin miscompares++; test_done(); end
    task cyc(input int n); repeat (n) @(posedge clock); #2; endtask
    task check_out(input logic exp);
        num_checks++;
        if (reset_out !== exp || reset_out_n !== !exp) begin
            miscompares++;
            $display("Error %0t: got %h/%h expected %h", $time, reset_out, reset_out_n, exp);
        end
    endtask
    task t_powerup;
        cyc(40); check_out(1);
        supply_sense_in = 2'h1; cyc(40); check_out(1);
        supply_sense_in = 2'h3; cyc(RST); check_out(1);
        cyc(8); check_out(0);
    endtask
    task t_drop;
        for (int i = 0; i < 2; i++) begin
            supply_sense_in = ~(2'h1 << i); cyc(4); check_out(1);
            supply_sense_in = 2'h3; cyc(RST + 8); check_out(0);
        end
    endtask
    task t_manual;
        manual_reset_request_n = 1'h0; cyc(4); check_out(1);
        manual_reset_request_n = 1'h1; cyc(RST); check_out(1);
        cyc(8); check_out(0);
    endtask
    task t_watchdog;
        cyc(3 * WDT); check_out(0);
        strobe_en = 1'h0; cyc(WDT - 8); check_out(0);
        for (int i = 0; i < 20 && reset_out !== 1'h1; i++) cyc(1);
        check_out(1);
        strobe_en = 1'h1; cyc(RST - 4); check_out(1);
        cyc(10); check_out(0);
    endtask
    initial begin
        cyc(1); check_out(1);
        cyc(11); reset_n = 1'h1;
        t_powerup; t_drop; t_manual; t_watchdog;
        test_done();
    end
endmodule
